// ==== shared/spr_cfg.svh ====
`ifndef SPR_CFG_SVH
`define SPR_CFG_SVH
// register byte offsets
`define SPR_OFS_STAT 8'h00
`define SPR_OFS_DATA 8'h04
`define SPR_OFS_BAUD 8'h08
`define SPR_OFS_MODE 8'h0c
`define SPR_OFS_DIV 8'h10
`define SPR_OFS_IRQ 8'h14
// receive_status_control_reg fields
`define SPR_PORT_EN_BIT 7
`define SPR_NINE_BIT 6
`define SPR_SINGLE_BIT 5
`define SPR_CONT_BIT 4
`define SPR_OVERRUN_BIT 1
`define SPR_NINTH_BIT 0
// baud_rate_control fields
`define SPR_ABOVF_BIT 7
`define SPR_IDLE_BIT 6
`define SPR_POL_BIT 4
`define SPR_WIDE_BIT 3
`define SPR_WAKE_BIT 1
`define SPR_ABEN_BIT 0
// mode register fields
`define SPR_SYNC_BIT 0
`define SPR_MASTER_BIT 1
// divisor register: high byte 15:8, low byte 7:0, speed bit
`define SPR_HSPEED_BIT 16
// interrupt enable register fields
`define SPR_RIE_BIT 0
`define SPR_PERIPHERAL_IRQ_ENABLE_BIT 1
`define SPR_GIE_BIT 2
`define SPR_PEND_BIT 8
// character lengths
`define SPR_CHAR8 4'd8
`define SPR_CHAR9 4'd9
`endif

// ==== shared/spr_pkg.sv ====
package spr_pkg;
  // master clock generator phases
  typedef enum logic [2:0] {
    SPR_IDLE = 3'b001,
    SPR_LEAD = 3'b010,
    SPR_TRAIL = 3'b100
  } spr_clk_state_type;
endpackage

// ==== verilog/spr_rx.sv ====
`timescale 1ns/1ps
`include "spr_cfg.svh"
// Functional notes
// - pending high while enabled and FIFO unread
// - irq needs all three enables set
// - pending independent of interrupt enables
// - polarity set: data clocked on rising edge
// - wake enable: falling edge sets flag, self-clears
// - autobaud enable self-clears when measurement completes
// - master receive: data pin driver off
// - single or continuous enable starts reception
// - single only: one character, then self-clears
// - continuous: clock until cleared, abort discards
// - both set: single clears, continuous continues
// - sample data on trailing clock edge
// - complete char pushes FIFO, head readable
// - slave: clock from pin, driver off
// - data changes leading, valid trailing edge
// - third char: overrun, keep FIFO, stop
// - overrun cleared by removing its cause
// - nine-bit option shifts nine, ninth readable
// - status shows head ninth bit, errors
// - data register read pops oldest char
module spr_rx #(
  parameter int FIFO_DEPTH = 2,
  parameter int AB_WIDTH = 16
) (
  // system
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial data pin
  input wire logic serial_data_pin_lvl,
  output logic serial_data_pin_drive,
  output logic serial_data_pin_oe,
  // serial clock pin
  input wire logic serial_clock_pin_lvl,
  output logic serial_clock_pin_drive,
  output logic serial_clock_pin_oe,
  // interrupt
  output logic rx_irq
);
  // control bits
  logic port_enable_q, nine_q, single_q, cont_q, sync_q, master_q;
  logic pol_q, wide_q, wake_en_q, aben_q, abovf_q, hspeed_q;
  logic [15:0] div_q;
  logic rie_q, peripheral_irq_enable_q, gie_q;
  // bus phase state
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q, rd_word;
  // pin synchronisers: first stage read only by second
  logic sd1_q, sd2_q, sd_prev_q, ck1_q, ck2_q, ck_prev_q;
  // master clock generator
  spr_pkg::spr_clk_state_type mst_q;
  logic [15:0] hcnt_q;
  logic ck_q, ck_oe_q;
  // shifter and fifo
  logic [8:0] sh_q;
  logic [3:0] bitcnt_q;
  logic [8:0] mem_q [FIFO_DEPTH];
  logic wptr_q, rptr_q;
  logic [1:0] cnt_q;
  logic ovr_q, ovr_single_q, wake_q, pend_q, irq_q;
  logic ab_run_q;
  logic [AB_WIDTH-1:0] ab_cnt_q;

  // bus decode
  logic acc, rd_data, pop, full;
  assign acc = hsel & htrans[1] & hready;
  assign rd_data = acc & ~hwrite & (haddr[7:0] == `SPR_OFS_DATA);
  assign full = (cnt_q == 2'(FIFO_DEPTH));
  assign pop = rd_data & (cnt_q != 2'd0);

  // write helper: data-phase write hit on an offset
  function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = pend & (a == ofs);
  endfunction

  // receive activity and edge events
  logic rx_on, half_end, mst_trail, slv_trail, sample, char_done;
  logic [15:0] half;
  logic [3:0] nbits;
  logic [8:0] shifted, word;
  logic sd_fall, wake_set;
  // overrun blocks all further sampling
  assign rx_on = port_enable_q & sync_q & (single_q | cont_q) & ~ovr_q;
  assign half = wide_q ? div_q : {8'h00, div_q[7:0]};
  assign half_end = (hcnt_q == half);
  assign mst_trail = (mst_q == spr_pkg::SPR_LEAD) & half_end;
  // trailing edge is the return to the idle level set by polarity
  assign slv_trail = (ck2_q != ck_prev_q) & (ck2_q == pol_q);
  assign sample = rx_on & (master_q ? mst_trail : slv_trail);
  assign nbits = nine_q ? `SPR_CHAR9 : `SPR_CHAR8;
  assign char_done = sample & (bitcnt_q == nbits - 4'd1);
  assign shifted = {sd2_q, sh_q[8:1]};
  assign word = nine_q ? shifted : {1'b0, shifted[8:1]};
  assign sd_fall = sd_prev_q & ~sd2_q;
  assign wake_set = port_enable_q & ~sync_q & wake_en_q & sd_fall;

  // register read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      `SPR_OFS_STAT:
      begin
        rd_word[`SPR_PORT_EN_BIT] = port_enable_q;
        rd_word[`SPR_NINE_BIT] = nine_q;
        rd_word[`SPR_SINGLE_BIT] = single_q;
        rd_word[`SPR_CONT_BIT] = cont_q;
        rd_word[`SPR_OVERRUN_BIT] = ovr_q;
        // head entry ninth bit, valid before the data read pops it
        rd_word[`SPR_NINTH_BIT] = mem_q[rptr_q][8];
      end
      `SPR_OFS_DATA: rd_word[7:0] = mem_q[rptr_q][7:0];
      `SPR_OFS_BAUD:
      begin
        rd_word[`SPR_ABOVF_BIT] = abovf_q;
        rd_word[`SPR_IDLE_BIT] = ~(ab_run_q | (bitcnt_q != 4'd0));
        rd_word[`SPR_POL_BIT] = pol_q;
        rd_word[`SPR_WIDE_BIT] = wide_q;
        rd_word[`SPR_WAKE_BIT] = wake_en_q;
        rd_word[`SPR_ABEN_BIT] = aben_q;
      end
      `SPR_OFS_MODE:
      begin
        rd_word[`SPR_SYNC_BIT] = sync_q;
        rd_word[`SPR_MASTER_BIT] = master_q;
      end
      `SPR_OFS_DIV: rd_word = {15'h0000, hspeed_q, div_q};
      `SPR_OFS_IRQ:
      begin
        rd_word[`SPR_RIE_BIT] = rie_q;
        rd_word[`SPR_PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_q;
        rd_word[`SPR_GIE_BIT] = gie_q;
        rd_word[`SPR_PEND_BIT] = pend_q;
      end
      default: rd_word = 32'h0000_0000; // unmapped reads as zero
    endcase
  end

  // bus phases: zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= acc & hwrite;
      wr_addr_q <= haddr[7:0];
      if (acc & ~hwrite)
        hrdata_q <= rd_word;
    end
  end

  // status/control register; single enable self-clears on a completed character
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_enable_q <= 1'b0;
      nine_q <= 1'b0;
      single_q <= 1'b0;
      cont_q <= 1'b0;
    end
    else if (wr_hit(wr_pend_q, wr_addr_q, `SPR_OFS_STAT))
    begin
      port_enable_q <= hwdata[`SPR_PORT_EN_BIT];
      nine_q <= hwdata[`SPR_NINE_BIT];
      single_q <= hwdata[`SPR_SINGLE_BIT];
      cont_q <= hwdata[`SPR_CONT_BIT];
    end
    else if (char_done)
      single_q <= 1'b0;
  end

  // mode, divisor and interrupt enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_q <= 1'b0;
      master_q <= 1'b0;
      hspeed_q <= 1'b0;
      rie_q <= 1'b0;
      peripheral_irq_enable_q <= 1'b0;
      gie_q <= 1'b0;
    end
    else
    begin
      if (wr_hit(wr_pend_q, wr_addr_q, `SPR_OFS_MODE))
      begin
        sync_q <= hwdata[`SPR_SYNC_BIT];
        master_q <= hwdata[`SPR_MASTER_BIT];
      end
      if (wr_hit(wr_pend_q, wr_addr_q, `SPR_OFS_DIV))
        hspeed_q <= hwdata[`SPR_HSPEED_BIT];
      if (wr_hit(wr_pend_q, wr_addr_q, `SPR_OFS_IRQ))
      begin
        rie_q <= hwdata[`SPR_RIE_BIT];
        peripheral_irq_enable_q <= hwdata[`SPR_PERIPHERAL_IRQ_ENABLE_BIT];
        gie_q <= hwdata[`SPR_GIE_BIT];
      end
    end
  end

  // baud control with self-clearing wake and autobaud bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pol_q <= 1'b0;
      wide_q <= 1'b0;
      wake_en_q <= 1'b0;
      aben_q <= 1'b0;
    end
    else if (wr_hit(wr_pend_q, wr_addr_q, `SPR_OFS_BAUD))
    begin
      pol_q <= hwdata[`SPR_POL_BIT];
      wide_q <= hwdata[`SPR_WIDE_BIT];
      wake_en_q <= hwdata[`SPR_WAKE_BIT];
      aben_q <= hwdata[`SPR_ABEN_BIT];
    end
    else
    begin
      if (wake_set)
        wake_en_q <= 1'b0;
      if (ab_run_q & sd_fall)
        aben_q <= 1'b0;
    end
  end

  // autobaud: count clocks between two falling edges, load divisor
  // only the span is measured; divisor scaling is left to software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ab_run_q <= 1'b0;
      ab_cnt_q <= '0;
      abovf_q <= 1'b0;
      div_q <= 16'h0000;
    end
    else if (wr_hit(wr_pend_q, wr_addr_q, `SPR_OFS_DIV))
      div_q <= hwdata[15:0];
    else if (!(port_enable_q & ~sync_q & aben_q))
      ab_run_q <= 1'b0;
    else if (sd_fall & ~ab_run_q)
    begin
      ab_run_q <= 1'b1;
      ab_cnt_q <= '0;
      abovf_q <= 1'b0;
    end
    else if (ab_run_q & sd_fall)
    begin
      ab_run_q <= 1'b0;
      div_q <= 16'(ab_cnt_q);
    end
    else if (ab_run_q)
    begin
      if (&ab_cnt_q)
        abovf_q <= 1'b1; // counter saturates on overflow
      else
        ab_cnt_q <= ab_cnt_q + AB_WIDTH'(1);
    end
  end

  // two-flop synchronisers on both pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sd1_q <= 1'b1;
      sd2_q <= 1'b1;
      sd_prev_q <= 1'b1;
      ck1_q <= 1'b0;
      ck2_q <= 1'b0;
      ck_prev_q <= 1'b0;
    end
    else
    begin
      sd1_q <= serial_data_pin_lvl;
      sd2_q <= sd1_q;
      sd_prev_q <= sd2_q;
      ck1_q <= serial_clock_pin_lvl;
      ck2_q <= ck1_q;
      ck_prev_q <= ck2_q;
    end
  end

  // master clock: half period of divisor+1 system clocks, low divisor byte only unless wide set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mst_q <= spr_pkg::SPR_IDLE;
      hcnt_q <= 16'h0000;
      ck_q <= 1'b0;
    end
    else if (!(rx_on & master_q))
    begin
      mst_q <= spr_pkg::SPR_IDLE; // stop at once
      hcnt_q <= 16'h0000;
      ck_q <= pol_q;
    end
    else
    begin
      unique case (mst_q)
        spr_pkg::SPR_IDLE:
        begin
          mst_q <= spr_pkg::SPR_LEAD;
          ck_q <= ~pol_q; // leading edge
        end
        spr_pkg::SPR_LEAD:
        begin
          hcnt_q <= half_end ? 16'h0000 : hcnt_q + 16'h0001;
          if (half_end)
          begin
            mst_q <= spr_pkg::SPR_TRAIL;
            ck_q <= pol_q; // trailing edge
          end
        end
        spr_pkg::SPR_TRAIL:
        begin
          hcnt_q <= half_end ? 16'h0000 : hcnt_q + 16'h0001;
          if (half_end)
          begin
            mst_q <= spr_pkg::SPR_LEAD; // no pause
            ck_q <= ~pol_q;
          end
        end
      endcase
    end
  end

  // shifter; dropping the enable discards a partial character
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sh_q <= 9'h000;
      bitcnt_q <= 4'd0;
    end
    else if (!rx_on)
      bitcnt_q <= 4'd0;
    else if (sample)
    begin
      sh_q <= shifted;
      bitcnt_q <= char_done ? 4'd0 : bitcnt_q + 4'd1;
    end
  end

  // two-entry fifo; full arrival raises overrun instead of writing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'd0;
      ovr_q <= 1'b0;
      ovr_single_q <= 1'b0;
      mem_q <= '{default: 9'h000};
    end
    else if (!port_enable_q)
    begin
      wptr_q <= 1'b0; // port disable resets the port
      rptr_q <= 1'b0;
      cnt_q <= 2'd0;
      ovr_q <= 1'b0;
    end
    else
    begin
      if (char_done & ~full)
      begin
        mem_q[wptr_q] <= word;
        wptr_q <= ~wptr_q;
      end
      if (pop)
        rptr_q <= ~rptr_q;
      cnt_q <= cnt_q + 2'((char_done & ~full) ? 1 : 0) - 2'(pop ? 1 : 0);
      if (char_done & full)
      begin
        ovr_q <= 1'b1;
        ovr_single_q <= ~cont_q;
      end
      else if (ovr_q & (ovr_single_q ? rd_data : ~cont_q))
        ovr_q <= 1'b0;
    end
  end

  // wake flag, pending flag and gated interrupt
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_q <= 1'b0;
      pend_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wake_set)
        wake_q <= 1'b1; // set wins over the read clear
      else if (rd_data | ~port_enable_q)
        wake_q <= 1'b0;
      pend_q <= port_enable_q & ((cnt_q != 2'd0) | wake_q);
      irq_q <= pend_q & rie_q & peripheral_irq_enable_q & gie_q;
    end
  end

  // pin drivers: data pin never driven, clock only as master
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ck_oe_q <= 1'b0;
    else
      ck_oe_q <= port_enable_q & sync_q & master_q;
  end

  assign serial_data_pin_drive = 1'b0;
  assign serial_data_pin_oe = 1'b0;
  assign serial_clock_pin_drive = ck_q;
  assign serial_clock_pin_oe = ck_oe_q;
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rx_irq = irq_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_irq_gate: assert property (rx_irq == $past(pend_q & rie_q & peripheral_irq_enable_q & gie_q))
    else $error("irq not gated by enables");
  a_pend_fifo: assert property (port_enable_q && cnt_q != 2'd0 |=> pend_q)
    else $error("pending low with unread data");
  a_data_quiet: assert property (!serial_data_pin_oe)
    else $error("data pin driven");
  a_single_once: assert property (char_done && !cont_q && !wr_pend_q |=> !single_q)
    else $error("single enable not cleared");
  a_cont_abort: assert property ($fell(cont_q) && !single_q |=> bitcnt_q == 4'd0)
    else $error("partial char kept");
  a_ovr_hold: assert property (ovr_q && !pop && port_enable_q |=> cnt_q == $past(cnt_q))
    else $error("fifo changed in overrun");
  a_push_count: assert property (char_done && !full && !pop && port_enable_q
    |=> cnt_q == $past(cnt_q) + 2'd1)
    else $error("char not pushed");
  a_slave_clk: assert property (port_enable_q && sync_q && !master_q ##1 port_enable_q && sync_q
    && !master_q |-> !serial_clock_pin_oe)
    else $error("slave drives clock");
  a_wake_clear: assert property (wake_set && !wr_pend_q |=> !wake_en_q && wake_q)
    else $error("wake not handled");
endmodule

// ==== verification/spr_partner.sv ====
`timescale 1ns/1ps
module spr_partner (
  // resolved clock level and its idle level
  input wire logic sclk,
  input wire logic pol,
  // lines driven towards the port
  output logic data_out,
  output logic sclk_out
);
  logic [26:0] bits_q; // bits still to send, lsb first
  int left_q; // count of bits still to send

  // quiet lines until a frame is armed
  initial
  begin
    data_out = 1'b1;
    sclk_out = 1'b0;
    left_q = 0;
    bits_q = '0;
  end

  // arm a frame of n bits
  task automatic load(input logic [26:0] v, input int n);
    bits_q = v;
    left_q = n;
  endtask

  // leading edge moves away from idle: next bit goes out
  always @(sclk)
  begin
    if (sclk !== pol)
    begin
      if (left_q > 0)
      begin
        data_out = bits_q[0];
        bits_q = bits_q >> 1;
        left_q = left_q - 1;
      end
      else
        data_out = ~data_out; // past the frame the line holds nothing useful
    end
  end

  // slave clocking: exactly n cycles of 400 ns, standing at idle after
  task automatic clock_out(input int n);
    for (int i = 0; i < n; i++)
    begin
      sclk_out = ~pol;
      #200;
      sclk_out = pol;
      #200;
    end
  endtask

  // one falling edge on the data line
  task automatic fall_edge();
    data_out = 1'b1;
    #400;
    data_out = 1'b0;
    #400;
    data_out = 1'b1;
  endtask
endmodule

// ==== verification/serial_port_receive_path_bench.sv ====
`timescale 1ns/1ps
`include "spr_cfg.svh"
module serial_port_receive_path_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic data_drive, data_oe, clk_drive, clk_oe; // device pin controls
  logic part_data, part_sclk, pol_sel; // far side lines and idle level
  wire logic link_clk, link_data; // resolved pin levels
  int n_mismatch, check_count, n_tog;

  // whoever enables wins the wire
  assign link_clk = clk_oe ? clk_drive : part_sclk;
  assign link_data = data_oe ? data_drive : part_data;

  // 20 mhz system clock
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  spr_rx i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .serial_data_pin_lvl(link_data), .serial_data_pin_drive(data_drive),
    .serial_data_pin_oe(data_oe), .serial_clock_pin_lvl(link_clk),
    .serial_clock_pin_drive(clk_drive), .serial_clock_pin_oe(clk_oe), .rx_irq(rx_irq)
  );
  spr_partner i_far (.sclk(link_clk), .pol(pol_sel), .data_out(part_data),
    .sclk_out(part_sclk));

  // count master clock toggles while the pin is driven
  always @(clk_drive)
    if (clk_oe === 1'b1)
      n_tog++;

  // compare and report
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask

  // poll until masked bits match; the watchdog bounds it
  task automatic wait_bits(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    q = ~v;
    while ((q & m) !== v)
      bus(1'b0, a, 32'h0, q);
  endtask

  // arm the far side, then start reception
  task automatic start_rx(input logic [31:0] st, input logic [26:0] v, input int n);
    i_far.load(v, n);
    n_tog = 0;
    wr(`SPR_OFS_STAT, st);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, well beyond the expected run
  initial
  begin
    #(50 * 20000);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    logic [31:0] q;
    int k;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'b010;
    pol_sel = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("baud reset", `SPR_OFS_BAUD, 32'h40);
    rd_chk("status reset", `SPR_OFS_STAT, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    $display("test reset done");
    // synchronous master, both polarities
    wr(`SPR_OFS_DIV, 32'h2);
    rd_chk("divisor", `SPR_OFS_DIV, 32'h2);
    wr(`SPR_OFS_MODE, 32'h3);
    for (int p = 0; p < 2; p++)
    begin
      pol_sel = p[0];
      wr(`SPR_OFS_BAUD, {27'h0, p[0], 4'h0});
      wr(`SPR_OFS_STAT, 32'h80);
      start_rx(32'ha0, p ? 27'h3c : 27'ha5, 8);
      wait_bits(`SPR_OFS_STAT, 32'h20, 32'h0);
      check("toggles", 32'(n_tog), 32'd16);
      check("clock idle", clk_drive, p[0]);
      check("clock oe", clk_oe, 1'b1);
      check("data oe", data_oe, 1'b0);
      rd_chk("pending polled", `SPR_OFS_IRQ, 32'h100);
      check("irq masked", rx_irq, 1'b0);
      rd_chk("data", `SPR_OFS_DATA, p ? 32'h3c : 32'ha5);
      rd_chk("pending empty", `SPR_OFS_IRQ, 32'h0);
    end
    pol_sel = 1'b0;
    wr(`SPR_OFS_BAUD, 32'h0);
    $display("test master single done");
    // nine-bit character with interrupt gating
    wr(`SPR_OFS_IRQ, 32'h3);
    start_rx(32'he0, 27'h1c3, 9);
    wait_bits(`SPR_OFS_STAT, 32'h20, 32'h0);
    check("nine toggles", 32'(n_tog), 32'd18);
    check("irq no global", rx_irq, 1'b0);
    wr(`SPR_OFS_IRQ, 32'h7);
    rd_chk("ninth bit", `SPR_OFS_STAT, 32'hc1);
    check("irq all set", rx_irq, 1'b1);
    rd_chk("nine data", `SPR_OFS_DATA, 32'hc3);
    rd_chk("popped", `SPR_OFS_IRQ, 32'h7);
    check("irq dropped", rx_irq, 1'b0);
    wr(`SPR_OFS_IRQ, 32'h0);
    $display("test nine bit done");
    // both enables, continuous run into overrun
    start_rx(32'hb0, {3'h0, 8'h33, 8'h22, 8'h11}, 24);
    wait_bits(`SPR_OFS_STAT, 32'h02, 32'h02);
    rd_chk("single dropped", `SPR_OFS_STAT, 32'h92);
    check("halted", 32'(n_tog), 32'd48);
    rd_chk("first kept", `SPR_OFS_DATA, 32'h11);
    rd_chk("second kept", `SPR_OFS_DATA, 32'h22);
    rd_chk("overrun held", `SPR_OFS_STAT, 32'h92);
    wr(`SPR_OFS_STAT, 32'h80);
    // overrun drops one cycle after the continuous enable clears
    @(posedge hclk);
    rd_chk("overrun gone", `SPR_OFS_STAT, 32'h80);
    $display("test overrun done");
    // abort in mid-character
    start_rx(32'h90, 27'hff, 8);
    while (n_tog < 8)
      @(posedge hclk);
    wr(`SPR_OFS_STAT, 32'h80);
    rd_chk("partial gone", `SPR_OFS_IRQ, 32'h0);
    k = n_tog;
    repeat (40) @(posedge hclk);
    check("clock stopped", 32'(n_tog), 32'(k));
    $display("test abort done");
    // single mode overrun, cleared by a data read; first char proves abort reset
    for (int i = 0; i < 3; i++)
    begin
      start_rx(32'ha0, 27'h41 + 27'(i), 8);
      wait_bits(`SPR_OFS_STAT, 32'h20, 32'h0);
    end
    rd_chk("single overrun", `SPR_OFS_STAT, 32'h82);
    rd_chk("single first", `SPR_OFS_DATA, 32'h41);
    rd_chk("single cleared", `SPR_OFS_STAT, 32'h80);
    rd_chk("single second", `SPR_OFS_DATA, 32'h42);
    $display("test single overrun done");
    // slave, clock from the far side at 400 ns
    wr(`SPR_OFS_MODE, 32'h1);
    start_rx(32'h90, 27'h5a, 8);
    check("slave clock oe", clk_oe, 1'b0);
    #7;
    i_far.clock_out(8);
    @(posedge hclk);
    wait_bits(`SPR_OFS_IRQ, 32'h100, 32'h100);
    rd_chk("slave data", `SPR_OFS_DATA, 32'h5a);
    $display("test slave done");
    // asynchronous wake edge and auto-baud clear
    wr(`SPR_OFS_MODE, 32'h0);
    wr(`SPR_OFS_BAUD, 32'h2);
    i_far.fall_edge();
    @(posedge hclk);
    bus(1'b0, `SPR_OFS_BAUD, 32'h0, q);
    check("wake cleared", q[1], 1'b0);
    rd_chk("wake pending", `SPR_OFS_IRQ, 32'h100);
    bus(1'b0, `SPR_OFS_DATA, 32'h0, q);
    wr(`SPR_OFS_BAUD, 32'h1);
    i_far.fall_edge();
    i_far.fall_edge();
    @(posedge hclk);
    bus(1'b0, `SPR_OFS_BAUD, 32'h0, q);
    check("autobaud cleared", q[0], 1'b0);
    $display("test async done");
    final_report();
  end
endmodule
